// ==== hw/plob_bank.v ====
// Purpose: phy/link override bank with wishbone classic slave and decode
// Assumes: inputs synchronous to mclk; 32-bit wishbone, byte addressed
// Notes: all outputs registered; ce low freezes everything but reset sync
//
// Function
// - skip interval code selects ordered-set spacing
// - scrambler bypass bit bypasses all lanes
// - alignment mode chooses relaxed or confirmed update
// - tx powerdown bar rises after boot; its mode bit has no effect
// - fast training count adds offset to number
// - short and medium set count decode
// - long set count decode
// - force second gen skips speed negotiation
// - exit latency profile table lookup
// - three independent lane reversal controls
// - five-bit link config, default one
// - receiver detect bypass skips detection
// - compliance disable blocks compliance entry
// - feedback ratio is field plus one
// - reference ratio is low bit plus one
// - pll reset from counter or bit
// - cascaded divider test output unless ratio one
// - idle detector disable holds async idle low
// - detect block forces rx idle low
// - recovery enable mode selects enable logic
// - frequency bypass replaces estimator output
// - phase bypass replaces phase counter output
//
// Chosen here: register access over Wishbone.
`include "plob_defines.vh"
module plob_bank #(
  parameter PLL_RST_CYCLES = (`PLOB_PLL_RST_NS + `PLOB_CLK_NS - 1) /
    `PLOB_CLK_NS
) (
  input wire mclk,
  input wire arst_n,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire shift_detect,
  input wire shift_confirm,
  input wire raw_elec_idle,
  input wire recovery_enable_input,
  input wire pll_powerup,
  input wire [5:0] freq_estimate,
  input wire [6:0] phase_count,
  output reg [11:0] skp_interval,
  output reg skp_insert_en,
  output reg scrambler_bypass,
  output reg alignment_mode,
  output reg symbol_update,
  output reg data_valid,
  output reg tx_powerdown_bar,
  output reg [12:0] fast_training_sets,
  output reg [7:0] short_set_count,
  output reg [7:0] medium_set_count,
  output reg [13:0] long_set_count,
  output reg force_second_gen,
  output reg [2:0] l0s_exit_latency,
  output reg [2:0] l1_exit_latency,
  output reg [7:0] fast_training_number,
  output reg [2:0] l0s_accept_latency,
  output reg [2:0] l1_accept_latency,
  output reg l0s_supported,
  output reg l1_supported,
  output reg controller_lane_reverse,
  output reg phy_lane_reverse,
  output reg full_lane_reverse,
  output reg [4:0] link_config,
  output reg receiver_detect_bypass,
  output reg compliance_disable,
  output reg [7:0] pll_feedback_ratio,
  output reg [1:0] pll_reference_ratio,
  output reg pll_reset,
  output reg pll_test_output,
  output reg async_elec_idle,
  output reg rx_elec_idle,
  output reg recovery_enable,
  output reg [5:0] freq_estimator_out,
  output reg [6:0] phase_counter_out
);
  // pulse counter is 8 bits wide; longer pulses need a wider counter
  localparam [31:0] RST_CNT_W = PLL_RST_CYCLES;
  localparam [7:0] RST_CNT = RST_CNT_W[7:0];

  // latency codes: 0 is shortest, 7 is the open-ended longest bucket
  function [21:0] exit_profile;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: exit_profile = {3'h0, 3'h0, 8'd24, 3'h6, 3'h7, 2'b11};
        4'h1: exit_profile = {3'h7, 3'h7, 8'd255, 3'h0, 3'h0, 2'b00};
        4'h2: exit_profile = {3'h7, 3'h0, 8'd255, 3'h0, 3'h7, 2'b01};
        4'h3: exit_profile = {3'h2, 3'h1, 8'd24, 3'h4, 3'h7, 2'b11};
        4'h4: exit_profile = {3'h1, 3'h0, 8'd12, 3'h3, 3'h7, 2'b11};
        4'h5: exit_profile = {3'h7, 3'h1, 8'd255, 3'h0, 3'h7, 2'b01};
        4'h6: exit_profile = {3'h2, 3'h7, 8'd24, 3'h4, 3'h0, 2'b10};
        4'h7: exit_profile = {3'h1, 3'h0, 8'd12, 3'h2, 3'h7, 2'b11};
        4'h8: exit_profile = {3'h1, 3'h0, 8'd12, 3'h4, 3'h7, 2'b11};
        4'h9: exit_profile = {3'h2, 3'h1, 8'd24, 3'h3, 3'h7, 2'b11};
        4'ha: exit_profile = {3'h1, 3'h7, 8'd12, 3'h3, 3'h0, 2'b10};
        4'hb: exit_profile = {3'h1, 3'h0, 8'd4, 3'h3, 3'h7, 2'b11};
        4'hc: exit_profile = {3'h4, 3'h3, 8'd48, 3'h3, 3'h7, 2'b11};
        4'hd: exit_profile = {3'h0, 3'h0, 8'd6, 3'h2, 3'h7, 2'b11};
        4'he: exit_profile = {3'h4, 3'h4, 8'd48, 3'h4, 3'h7, 2'b11};
        default: exit_profile = {3'h6, 3'h7, 8'd255, 3'h6, 3'h7, 2'b11};
      endcase
    end
  endfunction

  // undefined code 01 falls back to the shortest count
  function [7:0] mid_count;
    input [1:0] sel;
    begin
      case (sel)
        2'b10: mid_count = 8'd128;
        2'b11: mid_count = 8'd144;
        default: mid_count = 8'd16;
      endcase
    end
  endfunction

  function [31:0] byte_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer i;
    begin
      byte_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          byte_merge[i*8 +: 8] = wdat[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  reg [31:0] word4_q, word5_q, train_q, cfgrec_q, pllfb_q, pllrst_q;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [9:0] idx = wb_adr_i[11:2];
  reg [31:0] rd_d;
  reg hit_d;

  always @* begin
    hit_d = 1'b1;
    case (idx)
      {2'b00, `PLOB_IDX_WORD4}: rd_d = word4_q;
      {2'b00, `PLOB_IDX_WORD5}: rd_d = word5_q;
      {2'b00, `PLOB_IDX_TRAIN}: rd_d = train_q;
      {2'b00, `PLOB_IDX_CFGREC}: rd_d = cfgrec_q;
      {2'b00, `PLOB_IDX_PLLFB}: rd_d = pllfb_q;
      {2'b00, `PLOB_IDX_PLLRST}: rd_d = pllrst_q;
      default: begin
        rd_d = 32'h00000000;
        hit_d = 1'b0;
      end
    endcase
  end

  // one wait state: ack one edge after the request is seen
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word4_q <= `PLOB_RST_WORD4;
      word5_q <= `PLOB_RST_WORD5;
      train_q <= `PLOB_RST_TRAIN;
      cfgrec_q <= `PLOB_RST_CFGREC;
      pllfb_q <= `PLOB_RST_PLLFB;
      pllrst_q <= `PLOB_RST_PLLRST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : rd_d;
      end
      if (req && wb_we_i && hit_d) begin
        case (idx[7:0])
          `PLOB_IDX_WORD4: word4_q <= byte_merge(word4_q, wb_dat_i, wb_sel_i);
          `PLOB_IDX_WORD5: word5_q <= byte_merge(word5_q, wb_dat_i, wb_sel_i);
          `PLOB_IDX_TRAIN: train_q <= byte_merge(train_q, wb_dat_i, wb_sel_i);
          `PLOB_IDX_CFGREC:
            cfgrec_q <= byte_merge(cfgrec_q, wb_dat_i, wb_sel_i);
          `PLOB_IDX_PLLFB: pllfb_q <= byte_merge(pllfb_q, wb_dat_i, wb_sel_i);
          default: pllrst_q <= byte_merge(pllrst_q, wb_dat_i, wb_sel_i);
        endcase
      end
    end
  end

  // decoded views of the words
  wire [21:0] prof = exit_profile(train_q[`PLOB_EXIT_HI:`PLOB_EXIT_LO]);
  wire [7:0] nfts = prof[15:8];
  wire [2:0] skp_sel = train_q[`PLOB_SKP_HI:`PLOB_SKP_LO];
  wire [1:0] fts_sel = train_q[`PLOB_FTS_HI:`PLOB_FTS_LO];
  wire [1:0] long_sel = train_q[`PLOB_LONG_HI:`PLOB_LONG_LO];
  wire [7:0] nf = {1'b0, pllfb_q[`PLOB_CLKF_HI:`PLOB_CLKF_LO]} + 8'h01;
  wire [1:0] nr = {1'b0, pllrst_q[`PLOB_CLKR_LO]} + 2'b01;
  wire [8:0] test_div = nf * {6'h00, nr[1]} + {1'b0, nf};
  wire idle_gated = pllfb_q[`PLOB_IDLE_EN] & raw_elec_idle;

  reg [11:0] skp_d;
  reg [12:0] fts_add_d;
  reg [13:0] long_d;

  always @* begin
    case (skp_sel)
      3'b000: skp_d = 12'd1506;
      3'b001: skp_d = 12'd1538;
      3'b010: skp_d = 12'd1359;
      3'b011: skp_d = 12'd1180;
      3'b100: skp_d = 12'd2048;
      3'b101: skp_d = 12'd512;
      3'b110: skp_d = 12'd128;
      default: skp_d = 12'd0;
    endcase
    case (fts_sel)
      2'b01: fts_add_d = 13'd512;
      2'b10: fts_add_d = 13'd4096;
      2'b11: fts_add_d = 13'd4608;
      default: fts_add_d = 13'd0;
    endcase
    case (long_sel)
      2'b10: long_d = 14'd8096;
      2'b11: long_d = 14'd9120;
      default: long_d = 14'd1024;
    endcase
  end

  reg boot_done_q;
  reg pwr_seen_q;
  reg [7:0] rst_cnt_q;
  reg [8:0] div_cnt_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done_q <= 1'b0;
      pwr_seen_q <= 1'b0;
      rst_cnt_q <= 8'h00;
      div_cnt_q <= 9'h000;
      skp_interval <= 12'd1506;
      skp_insert_en <= 1'b1;
      scrambler_bypass <= 1'b0;
      alignment_mode <= 1'b0;
      symbol_update <= 1'b0;
      data_valid <= 1'b0;
      tx_powerdown_bar <= 1'b0;
      fast_training_sets <= 13'd24;
      short_set_count <= 8'd16;
      medium_set_count <= 8'd16;
      long_set_count <= 14'd1024;
      force_second_gen <= 1'b0;
      l0s_exit_latency <= 3'h0;
      l1_exit_latency <= 3'h0;
      fast_training_number <= 8'd24;
      l0s_accept_latency <= 3'h6;
      l1_accept_latency <= 3'h7;
      l0s_supported <= 1'b1;
      l1_supported <= 1'b1;
      controller_lane_reverse <= 1'b0;
      phy_lane_reverse <= 1'b0;
      full_lane_reverse <= 1'b0;
      link_config <= 5'h01;
      receiver_detect_bypass <= 1'b0;
      compliance_disable <= 1'b0;
      pll_feedback_ratio <= 8'h02;
      pll_reference_ratio <= 2'b01;
      pll_reset <= 1'b0;
      pll_test_output <= 1'b0;
      async_elec_idle <= 1'b0;
      rx_elec_idle <= 1'b0;
      recovery_enable <= 1'b0;
      freq_estimator_out <= 6'h00;
      phase_counter_out <= 7'h00;
    end else if (ce) begin
      boot_done_q <= 1'b1;
      skp_interval <= skp_d;
      skp_insert_en <= (skp_sel != 3'b111);
      scrambler_bypass <= train_q[`PLOB_SCR_BYPASS];
      alignment_mode <= train_q[`PLOB_ALIGN_MODE];
      // aggressive mode waits for confirmation; relaxed follows any shift
      symbol_update <= train_q[`PLOB_ALIGN_MODE] ? shift_confirm :
        shift_detect;
      data_valid <= ~train_q[`PLOB_ALIGN_MODE] | shift_confirm;
      // mode one can only be set by software, after boot_done_q has already
      // forced the output high, so it never changes tx_powerdown_bar
      tx_powerdown_bar <= train_q[`PLOB_TX_PD_MODE] | boot_done_q;
      fast_training_sets <= fts_add_d + {5'h00, nfts};
      short_set_count <= mid_count(train_q[`PLOB_SHORT_HI:`PLOB_SHORT_LO]);
      medium_set_count <= mid_count(train_q[`PLOB_MED_HI:`PLOB_MED_LO]);
      long_set_count <= long_d;
      force_second_gen <= train_q[`PLOB_GEN2];
      l0s_exit_latency <= prof[21:19];
      l1_exit_latency <= prof[18:16];
      fast_training_number <= nfts;
      l0s_accept_latency <= prof[7:5];
      l1_accept_latency <= prof[4:2];
      l0s_supported <= prof[1];
      l1_supported <= prof[0];
      controller_lane_reverse <= train_q[`PLOB_LC_REV];
      phy_lane_reverse <= train_q[`PLOB_PHY_REV];
      full_lane_reverse <= train_q[`PLOB_ALL_REV];
      link_config <= cfgrec_q[`PLOB_LCFG_HI:`PLOB_LCFG_LO];
      receiver_detect_bypass <= cfgrec_q[`PLOB_RXDET_BYP];
      compliance_disable <= cfgrec_q[`PLOB_COMPL_DIS];
      pll_feedback_ratio <= nf;
      pll_reference_ratio <= nr;
      // internal reset: a fixed pulse after each rising power-up
      pwr_seen_q <= pll_powerup;
      if (pll_powerup && !pwr_seen_q) begin
        rst_cnt_q <= RST_CNT;
      end else if (rst_cnt_q != 8'h00) begin
        rst_cnt_q <= rst_cnt_q - 8'h01;
      end
      pll_reset <= pllrst_q[`PLOB_PLLRST_SEL] ? pllrst_q[`PLOB_PLLRST] :
        (rst_cnt_q != 8'h00);
      // mclk stands in for the reference clock of the cascaded dividers
      if (!pllrst_q[`PLOB_PLLTEST] || nr == 2'b01 || nf == 8'h01) begin
        div_cnt_q <= 9'h000;
        pll_test_output <= 1'b0;
      end else begin
        div_cnt_q <= (div_cnt_q >= test_div - 9'h001) ? 9'h000 :
          div_cnt_q + 9'h001;
        pll_test_output <= (div_cnt_q < {1'b0, test_div[8:1]});
      end
      async_elec_idle <= idle_gated;
      rx_elec_idle <= idle_gated & ~train_q[`PLOB_DET_BLOCK];
      if (pllfb_q[`PLOB_CREN_MODE] || recovery_enable_input) begin
        recovery_enable <= 1'b1;
      end else if (idle_gated) begin
        recovery_enable <= 1'b0;
      end
      freq_estimator_out <= pllfb_q[`PLOB_FR_BYPASS] ?
        cfgrec_q[`PLOB_FRV_HI:`PLOB_FRV_LO] : freq_estimate;
      phase_counter_out <= pllrst_q[`PLOB_PH_BYPASS] ?
        pllrst_q[`PLOB_PHV_HI:`PLOB_PHV_LO] : phase_count;
    end
  end
endmodule // plob_bank

// ==== hw/plob_defines.vh ====
// Purpose: constants of the phy/link override bank
// Assumes: word index times four is the wishbone byte address
// Notes: definitions only
`ifndef PLOB_DEFINES_VH
`define PLOB_DEFINES_VH
`define PLOB_IDX_WORD4 8'h64
`define PLOB_IDX_WORD5 8'h65
`define PLOB_IDX_TRAIN 8'h66
`define PLOB_IDX_CFGREC 8'h67
`define PLOB_IDX_PLLFB 8'h68
`define PLOB_IDX_PLLRST 8'h69
`define PLOB_RST_WORD4 32'h00000000
`define PLOB_RST_WORD5 32'h00000000
`define PLOB_RST_TRAIN 32'h00000000
`define PLOB_RST_CFGREC 32'h4d802001
`define PLOB_RST_PLLFB 32'h81518901
`define PLOB_RST_PLLRST 32'h80000001
// training word fields
`define PLOB_TX_PD_MODE 3
`define PLOB_ALIGN_MODE 5
`define PLOB_SCR_BYPASS 10
`define PLOB_SKP_HI 14
`define PLOB_SKP_LO 12
`define PLOB_EXIT_HI 18
`define PLOB_EXIT_LO 15
`define PLOB_LC_REV 19
`define PLOB_PHY_REV 20
`define PLOB_ALL_REV 21
`define PLOB_FTS_HI 23
`define PLOB_FTS_LO 22
`define PLOB_SHORT_HI 25
`define PLOB_SHORT_LO 24
`define PLOB_MED_HI 27
`define PLOB_MED_LO 26
`define PLOB_LONG_HI 29
`define PLOB_LONG_LO 28
`define PLOB_GEN2 30
`define PLOB_DET_BLOCK 31
// config/recovery word fields
`define PLOB_LCFG_HI 4
`define PLOB_LCFG_LO 0
`define PLOB_RXDET_BYP 5
`define PLOB_COMPL_DIS 6
`define PLOB_FRV_HI 20
`define PLOB_FRV_LO 15
// pll feedback word fields
`define PLOB_FR_BYPASS 13
`define PLOB_CREN_MODE 14
`define PLOB_CLKF_HI 30
`define PLOB_CLKF_LO 24
`define PLOB_IDLE_EN 31
// pll reset word fields
`define PLOB_PHV_HI 16
`define PLOB_PHV_LO 10
`define PLOB_PH_BYPASS 17
`define PLOB_CLKR_LO 18
`define PLOB_PLLRST 20
`define PLOB_PLLRST_SEL 21
`define PLOB_PLLTEST 22
// internal pll reset pulse length
`define PLOB_PLL_RST_NS 640
`define PLOB_CLK_NS 10
`endif

// ==== tb/plob_bank_asserts.sv ====
// Purpose: bus and decode checks for the override bank
// Assumes: one mclk domain, arst_n async active low
// Notes: up_q masks the cycles while the reset copy drains
module plob_bank_chk (
  input wire mclk,
  input wire arst_n,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [11:0] skp_interval,
  input wire skp_insert_en,
  input wire alignment_mode,
  input wire data_valid,
  input wire tx_powerdown_bar,
  input wire [12:0] fast_training_sets,
  input wire [7:0] fast_training_number,
  input wire [7:0] short_set_count,
  input wire [13:0] long_set_count,
  input wire [7:0] pll_feedback_ratio,
  input wire [1:0] pll_reference_ratio,
  input wire raw_elec_idle,
  input wire async_elec_idle,
  input wire rx_elec_idle,
  input wire recovery_enable_input,
  input wire recovery_enable
);
  logic [2:0] up_q;
  logic up;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      up_q <= 3'h0;
    else if (up_q != 3'h6)
      up_q <= up_q + 3'h1;
  end
  assign up = (up_q == 3'h6);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  ack_resp_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack after request");
  ack_once_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmap_zero_a: assert property (wb_ack_o && !wb_we_i &&
    !(wb_adr_i inside {[12'h190:12'h1a7]}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  skp_en_a: assert property (skp_insert_en == (skp_interval != 12'h0))
    else $error("skip enable and interval disagree");
  fts_off_a: assert property (up |-> (fast_training_sets -
    13'(fast_training_number)) inside {13'h0,13'h200,13'h1000,13'h1200})
    else $error("training set offset illegal");
  short_cnt_a: assert property (short_set_count inside
    {8'h10,8'h80,8'h90}) else $error("short count illegal");
  long_cnt_a: assert property (long_set_count inside
    {14'h400,14'h1fa0,14'h23a0}) else $error("long count illegal");
  pll_ratio_a: assert property (
    pll_reference_ratio inside {2'h1,2'h2} && pll_feedback_ratio != 8'h0)
    else $error("pll ratio illegal");
  relax_dv_a: assert property (up && !alignment_mode &&
    !$past(alignment_mode) |-> data_valid) else $error("relaxed valid low");
  tx_pd_a: assert property (up |-> tx_powerdown_bar)
    else $error("tx powerdown bar low after boot");
  idle_off_a: assert property (!raw_elec_idle |=> !async_elec_idle)
    else $error("idle output without idle");
  rx_idle_a: assert property (rx_elec_idle |-> async_elec_idle)
    else $error("rx idle without async idle");
  recov_on_a: assert property (up && recovery_enable_input |=>
    recovery_enable) else $error("recovery not enabled");
endmodule // plob_bank_chk
bind plob_bank plob_bank_chk u_chk (.mclk(mclk), .arst_n(arst_n), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .skp_interval(skp_interval), .skp_insert_en(skp_insert_en),
  .alignment_mode(alignment_mode), .data_valid(data_valid),
  .tx_powerdown_bar(tx_powerdown_bar),
  .fast_training_sets(fast_training_sets),
  .fast_training_number(fast_training_number),
  .short_set_count(short_set_count), .long_set_count(long_set_count),
  .pll_feedback_ratio(pll_feedback_ratio),
  .pll_reference_ratio(pll_reference_ratio),
  .raw_elec_idle(raw_elec_idle), .async_elec_idle(async_elec_idle),
  .rx_elec_idle(rx_elec_idle), .recovery_enable(recovery_enable),
  .recovery_enable_input(recovery_enable_input));

// ==== tb/pcie_phy_link_override_bank_tb_top.sv ====
// Purpose: self-checking bench for the override bank
// Assumes: ce held high; outputs read at an edge, before its updates
// Notes: short pll reset pulse keeps the run brief
module pcie_phy_link_override_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, rd;
  logic shift_detect = 1'b0, shift_confirm = 1'b0, raw_elec_idle = 1'b0;
  logic recovery_enable_input = 1'b0, pll_powerup = 1'b0;
  logic [5:0] freq_estimate = 6'h15;
  logic [6:0] phase_count = 7'h2a;
  wire [31:0] wb_dat_o;
  wire [11:0] skp_interval;
  wire [12:0] fast_training_sets;
  wire [7:0] short_set_count, fast_training_number, pll_feedback_ratio;
  wire [13:0] long_set_count;
  wire [1:0] pll_reference_ratio;
  wire [4:0] link_config;
  wire [5:0] freq_estimator_out;
  wire [6:0] phase_counter_out;
  wire wb_ack_o, skp_insert_en, scrambler_bypass, data_valid, symbol_update;
  wire tx_powerdown_bar, force_second_gen, pll_reset;
  wire async_elec_idle, rx_elec_idle;
  wire [7:0] medium_set_count;
  wire [2:0] l0s_exit_latency, l1_exit_latency;
  wire [2:0] l0s_accept_latency, l1_accept_latency;
  wire l0s_supported, l1_supported, alignment_mode, recovery_enable;
  wire controller_lane_reverse, phy_lane_reverse, full_lane_reverse;
  wire receiver_detect_bypass, compliance_disable, pll_test_output;
  int err_count = 0, n_tests = 0;
  always #5 mclk = ~mclk;
  plob_bank #(.PLL_RST_CYCLES(4)) uut (.mclk(mclk), .arst_n(arst_n),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shift_detect(shift_detect),
    .shift_confirm(shift_confirm), .raw_elec_idle(raw_elec_idle),
    .recovery_enable_input(recovery_enable_input),
    .pll_powerup(pll_powerup), .freq_estimate(freq_estimate),
    .phase_count(phase_count), .skp_interval(skp_interval),
    .skp_insert_en(skp_insert_en), .scrambler_bypass(scrambler_bypass),
    .alignment_mode(alignment_mode), .symbol_update(symbol_update),
    .data_valid(data_valid), .tx_powerdown_bar(tx_powerdown_bar),
    .fast_training_sets(fast_training_sets),
    .short_set_count(short_set_count),
    .medium_set_count(medium_set_count),
    .long_set_count(long_set_count), .force_second_gen(force_second_gen),
    .l0s_exit_latency(l0s_exit_latency), .l1_exit_latency(l1_exit_latency),
    .fast_training_number(fast_training_number),
    .l0s_accept_latency(l0s_accept_latency),
    .l1_accept_latency(l1_accept_latency), .l0s_supported(l0s_supported),
    .l1_supported(l1_supported),
    .controller_lane_reverse(controller_lane_reverse),
    .phy_lane_reverse(phy_lane_reverse),
    .full_lane_reverse(full_lane_reverse), .link_config(link_config),
    .receiver_detect_bypass(receiver_detect_bypass),
    .compliance_disable(compliance_disable),
    .pll_feedback_ratio(pll_feedback_ratio),
    .pll_reference_ratio(pll_reference_ratio), .pll_reset(pll_reset),
    .pll_test_output(pll_test_output), .async_elec_idle(async_elec_idle),
    .rx_elec_idle(rx_elec_idle), .recovery_enable(recovery_enable),
    .freq_estimator_out(freq_estimator_out),
    .phase_counter_out(phase_counter_out));
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after an edge; read data lands in rd
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      end_sim();
    end
    @(posedge mclk);
  endtask
  task automatic t_regs;
    logic [31:0] dflt [6];
    dflt = '{32'h0, 32'h0, 32'h0, 32'h4d802001, 32'h81518901, 32'h80000001};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 12'h190 + 12'(4 * i), 32'h0);
      chk(rd, dflt[i]);
    end
    chk(link_config, 5'h1);
    chk({compliance_disable, receiver_detect_bypass}, 2'h0);
    wb(1'b1, 12'h1a8, 32'hffffffff);
    wb(1'b0, 12'h1a8, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 12'h190, 32'ha5a55a5a);
    wb(1'b0, 12'h190, 32'h0);
    chk(rd, 32'ha5a55a5a);
    wb_sel_i <= 4'h1;
    wb(1'b1, 12'h1a4, 32'hffffffff);
    wb_sel_i <= 4'hf;
    wb(1'b0, 12'h1a4, 32'h0);
    chk(rd, 32'h800000ff);
    $display("done regs");
  endtask
  task automatic t_skp;
    logic [11:0] t [8];
    t = '{12'h5e2, 12'h602, 12'h54f, 12'h49c, 12'h800, 12'h200, 12'h80, 12'h0};
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 12'h198, 32'(c) << 12);
      repeat (2) @(posedge mclk);
      chk(skp_interval, t[c]);
      chk(skp_insert_en, c != 7);
    end
    $display("done skip");
  endtask
  task automatic t_counts;
    logic [31:0] k, pr [4], nf [4], off [4], sh [4], lg [4], lt [4];
    pr = '{32'h0, 32'h2, 32'h6, 32'h1};
    nf = '{32'h18, 32'hff, 32'h18, 32'hff};
    lt = '{32'hdf, 32'h381d, 32'h1782, 32'h3f00};
    off = '{32'h0, 32'h200, 32'h1000, 32'h1200};
    sh = '{32'h10, 32'h10, 32'h80, 32'h90};
    lg = '{32'h400, 32'h400, 32'h1fa0, 32'h23a0};
    for (int i = 0; i < 4; i++) begin
      k = 32'(i);
      wb(1'b1, 12'h198, (k << 28) | (k << 26) | (k << 24) | (k << 22) |
        (pr[i] << 15) | (k << 19) | ((k[0] ^ k[1]) << 21) |
        (k[1] << 30) | (k[0] << 10));
      repeat (2) @(posedge mclk);
      chk(fast_training_number, nf[i]);
      chk(fast_training_sets, off[i] + nf[i]);
      chk(short_set_count, sh[i]);
      chk(medium_set_count, sh[i]);
      chk({l0s_exit_latency, l1_exit_latency, l0s_accept_latency,
        l1_accept_latency, l0s_supported, l1_supported}, lt[i]);
      chk({full_lane_reverse, phy_lane_reverse,
        controller_lane_reverse}, {k[0] ^ k[1], k[1], k[0]});
      chk(long_set_count, lg[i]);
      chk(scrambler_bypass, k[0]);
      chk(force_second_gen, k[1]);
    end
    $display("done counts");
  endtask
  task automatic t_align;
    shift_detect <= 1'b1;
    shift_confirm <= 1'b0;
    wb(1'b1, 12'h198, 32'h20);
    repeat (2) @(posedge mclk);
    chk({alignment_mode, data_valid, symbol_update}, 3'h4);
    shift_confirm <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({alignment_mode, data_valid, symbol_update}, 3'h7);
    shift_confirm <= 1'b0;
    wb(1'b1, 12'h198, 32'h0);
    repeat (2) @(posedge mclk);
    chk({alignment_mode, data_valid, symbol_update}, 3'h3);
    $display("done align");
  endtask
  task automatic t_pll;
    logic [31:0] hi;
    wb(1'b1, 12'h19c, 32'h0016804c);
    wb(1'b1, 12'h1a0, 32'haa002000);
    wb(1'b1, 12'h1a4, 32'h003f5400);
    repeat (2) @(posedge mclk);
    chk(freq_estimator_out, 6'h2d);
    chk(pll_feedback_ratio, 8'h2b);
    chk(phase_counter_out, 7'h55);
    chk(pll_reference_ratio, 2'h2);
    chk(pll_reset, 1'b1);
    chk(link_config, 5'hc);
    chk({compliance_disable, receiver_detect_bypass}, 2'h2);
    wb(1'b1, 12'h1a0, 32'haa000000);
    wb(1'b1, 12'h1a4, 32'h000d5400);
    wb(1'b1, 12'h19c, 32'h00000020);
    repeat (2) @(posedge mclk);
    chk(freq_estimator_out, freq_estimate);
    chk(phase_counter_out, phase_count);
    chk(pll_reset, 1'b0);
    chk(link_config, 5'h0);
    chk({compliance_disable, receiver_detect_bypass}, 2'h1);
    pll_powerup <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(pll_reset, 1'b1);
    repeat (3) @(posedge mclk);
    chk(pll_reset, 1'b1);
    @(posedge mclk);
    chk(pll_reset, 1'b0);
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, 12'h1a4, j ? 32'h00400000 : 32'h00440000);
      repeat (2) @(posedge mclk);
      hi = 32'h0;
      repeat (86) begin
        @(posedge mclk);
        hi = hi + 32'(pll_test_output);
      end
      // ratio 2 x 43: half of each 86-cycle period high; ratio 1 stays low
      chk(hi, j ? 32'h0 : 32'h2b);
    end
    $display("done pll");
  endtask
  task automatic t_idle;
    raw_elec_idle <= 1'b1;
    recovery_enable_input <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({recovery_enable, async_elec_idle, rx_elec_idle}, 3'h7);
    recovery_enable_input <= 1'b0;
    wb(1'b1, 12'h198, 32'h80000000);
    repeat (2) @(posedge mclk);
    chk({recovery_enable, async_elec_idle, rx_elec_idle}, 3'h2);
    wb(1'b1, 12'h1a0, 32'h2a004000);
    repeat (2) @(posedge mclk);
    chk({recovery_enable, async_elec_idle}, 2'h2);
    $display("done idle");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    chk(tx_powerdown_bar, 1'b0);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(tx_powerdown_bar, 1'b1);
    t_regs();
    t_skp();
    t_counts();
    t_align();
    t_pll();
    t_idle();
    end_sim();
  end
endmodule // pcie_phy_link_override_bank_tb_top
